// ===== rlt_timer.sv
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "rlt_defines.svh"
// What this block does
// - Mode bit: 0 interval, 1 auto-reload
// - Direction: 00 up, 01 down, 1x pin
// - Mode bits four, three read one
// - Clock select: six divisions, sub, event
// - Event edge chosen by polarity bit
// - Read-only 8-bit up/down counter
// - Overflow or underflow sets request flag
// - Counter read, reload write share address
// - Reload write also loads counter
// - Auto-reload loads reload on wrap
// - Reset: mode 18, counter reload 00
// - Standby bit zero halts the timer
// - Interval wraps to 00 or FF
// - Interrupt when flag and enable set
module rlt_timer
    import rlt_pkg::*;
(
    input  wire logic        mclk_i,        // 125 MHz system clock
    input  wire logic        nrst_i,        // Async reset, active low
    input  wire logic        psel_i,        // APB select
    input  wire logic        penable_i,     // APB access phase
    input  wire logic        pwrite_i,      // APB direction
    input  wire logic [17:0] paddr_i,       // APB byte address
    input  wire logic [31:0] pwdata_i,      // APB write data
    output logic      [31:0] prdata_o,      // APB read data
    output logic             pready_o,      // APB ready
    output logic             pslverr_o,     // APB error, unmapped
    input  wire logic        sub_clk_i,     // Sub-clock, sampled level
    input  wire logic        event_input_pin_i,       // Event edges
    input  wire logic        count_direction_pin_i,   // High counts down
    output logic             overflow_irq_o           // CPU request
);

    // Bundle the bus request
    rlt_apb_req_s req;
    assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                   addr: paddr_i, wdata: pwdata_i};

    // Register state
    rlt_mode_s                 mode_q, mode_d;     // Mode register
    logic [7:0]                count_q, count_d;   // count_value
    logic [7:0]                reload_q, reload_d; // reload_value
    logic [7:0]                gate_q, gate_d;     // module_clock_gate
    logic                      flag_q, flag_d;     // overflow_request_flag
    logic                      irq_en_q, irq_en_d; // overflow_irq_enable
    logic                      pol_q, pol_d;       // event_edge_polarity
    logic [31:0]               rdata_q, rdata_d;   // Read data register
    logic                      ready_q, ready_d;   // Ready register
    logic                      err_q, err_d;       // Error register
    logic                      irq_q, irq_d;       // Interrupt output
    // Count source state
    logic [`RLT_PRE_WIDTH-1:0] pre_q, pre_d;       // System prescaler
    logic [1:0]                sub_div_q, sub_div_d; // Sub-clock by 4
    logic [1:0]                sub_sync_q, sub_sync_d; // Sub-clock sync
    logic                      sub_last_q, sub_last_d; // Sub edge history
    logic [1:0]                ev_sync_q, ev_sync_d;   // Event sync
    logic                      ev_last_q, ev_last_d;   // Event history
    logic                      tick_q, tick_d;         // Count enable

    // Byte address of a register index
    function automatic logic [17:0] idx_addr(input logic [15:0] idx);
        idx_addr = {idx, 2'b00};
    endfunction

    // Rising edge of a selected prescaler tap
    function automatic logic tap_rise(input logic [`RLT_PRE_WIDTH-1:0] cur,
                                      input logic [`RLT_PRE_WIDTH-1:0] nxt,
                                      input int                       bit_n);
        tap_rise = !cur[bit_n] && nxt[bit_n];
    endfunction

    // Decode and access helpers
    logic       acc;           // Access phase this cycle
    logic       wr_ok;         // Write takes effect
    logic       hit_mode;      // Mode register hit
    logic       hit_count;     // Counter/reload hit
    logic       hit_gate;      // Gate register hit
    logic       hit_req;       // Request flag register hit
    logic       hit_en;        // Enable register hit
    logic       hit_edge;      // Edge select register hit
    logic       mapped;        // Any hit
    logic       running;       // Not in module standby
    logic       count_down;    // Effective direction
    logic       wrap;          // Overflow or underflow on this tick

    assign acc       = req.sel && req.enable;
    assign hit_mode  = req.addr == idx_addr(`RLT_IDX_MODE);
    assign hit_count = req.addr == idx_addr(`RLT_IDX_COUNT);
    assign hit_gate  = req.addr == idx_addr(`RLT_IDX_GATE);
    assign hit_req   = req.addr == idx_addr(`RLT_IDX_IRQ_REQ);
    assign hit_en    = req.addr == idx_addr(`RLT_IDX_IRQ_EN);
    assign hit_edge  = req.addr == idx_addr(`RLT_IDX_EDGE_SEL);
    assign mapped    = hit_mode || hit_count || hit_gate || hit_req
                       || hit_en || hit_edge;
    // Single-wait slave: ready is raised once, in the second access cycle
    assign wr_ok     = acc && req.write && !ready_q;
    assign running   = gate_q[`RLT_GATE_STBY_BIT];

    // Direction from mode bits or pin
    always_comb
    begin
        if (mode_q.hw_direction_bit)
        begin
            count_down = count_direction_pin_i;
        end
        else
        begin
            count_down = mode_q.sw_direction_bit;
        end
    end

    assign wrap = tick_q && (count_down ? (count_q == `RLT_COUNT_MIN)
                                        : (count_q == `RLT_COUNT_MAX));

    // Count source next state
    always_comb
    begin
        pre_d      = pre_q + 1'b1;
        sub_sync_d = {sub_sync_q[0], sub_clk_i};
        sub_last_d = sub_sync_q[1];
        sub_div_d  = sub_div_q;
        ev_sync_d  = {ev_sync_q[0], event_input_pin_i};
        ev_last_d  = ev_sync_q[1];
        tick_d     = 1'b0;
        // Sub-clock divided by four, edge counted after synchroniser
        if (sub_sync_q[1] && !sub_last_q)
        begin
            sub_div_d = sub_div_q + 1'b1;
        end
        if (!running)
        begin
            // Standby freezes the prescaler so restart is clean; the sub-clock divider keeps counting
            pre_d  = pre_q;
            tick_d = 1'b0;
        end
        else
        begin
            case (mode_q.clock_sel)
                RLT_CS_D8192: tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_8192);
                RLT_CS_D2048: tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_2048);
                RLT_CS_D512:  tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_512);
                RLT_CS_D64:   tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_64);
                RLT_CS_D16:   tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_16);
                RLT_CS_D4:    tick_d = tap_rise(pre_q, pre_d, `RLT_TAP_4);
                RLT_CS_SUBD4: tick_d = (sub_sync_q[1] && !sub_last_q)
                                       && (sub_div_q == 2'b11);
                RLT_CS_EXT:
                begin
                    // Polarity 1 picks rising, 0 falling
                    tick_d = pol_q ? (ev_sync_q[1] && !ev_last_q)
                                   : (!ev_sync_q[1] && ev_last_q);
                end
                default:      tick_d = 1'b0;
            endcase
        end
    end

    // Count source registers
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pre_q      <= '0;
            sub_div_q  <= 2'b00;
            sub_sync_q <= 2'b00;
            sub_last_q <= 1'b0;
            ev_sync_q  <= 2'b00;
            ev_last_q  <= 1'b0;
            tick_q     <= 1'b0;
        end
        else
        begin
            pre_q      <= pre_d;
            sub_div_q  <= sub_div_d;
            sub_sync_q <= sub_sync_d;
            sub_last_q <= sub_last_d;
            ev_sync_q  <= ev_sync_d;
            ev_last_q  <= ev_last_d;
            tick_q     <= tick_d;
        end
    end

    // Register file and counter next state
    always_comb
    begin
        mode_d   = mode_q;
        count_d  = count_q;
        reload_d = reload_q;
        gate_d   = gate_q;
        flag_d   = flag_q;
        irq_en_d = irq_en_q;
        pol_d    = pol_q;
        rdata_d  = rdata_q;
        ready_d  = acc && !ready_q;
        err_d    = acc && !ready_q && !mapped;
        // Counting, only when not in standby
        if (tick_q && running)
        begin
            if (wrap && mode_q.reload_mode_bit)
            begin
                count_d = reload_q;
            end
            else if (count_down)
            begin
                count_d = count_q - 1'b1;
            end
            else
            begin
                count_d = count_q + 1'b1;
            end
        end
        // Software clears the flag by writing zero
        if (wr_ok && hit_req && !req.wdata[0])
        begin
            flag_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (wrap && running)
        begin
            flag_d = 1'b1;
        end
        if (wr_ok)
        begin
            if (hit_mode)
            begin
                // Reserved bits held at one
                mode_d = rlt_mode_s'((req.wdata[7:0] & `RLT_MODE_WR_MASK)
                                     | `RLT_MODE_RSVD_MASK);
            end
            if (hit_count)
            begin
                reload_d = req.wdata[7:0];
                count_d  = req.wdata[7:0];
            end
            if (hit_gate)
            begin
                gate_d = req.wdata[7:0];
            end
            if (hit_en)
            begin
                irq_en_d = req.wdata[0];
            end
            if (hit_edge)
            begin
                pol_d = req.wdata[0];
            end
        end
        // Read data latched with ready
        if (acc && !ready_q && !req.write)
        begin
            rdata_d = 32'h0000_0000;
            if (hit_mode)
            begin
                rdata_d = {24'h00_0000, mode_q};
            end
            else if (hit_count)
            begin
                rdata_d = {24'h00_0000, count_q};
            end
            else if (hit_gate)
            begin
                rdata_d = {24'h00_0000, gate_q};
            end
            else if (hit_req)
            begin
                rdata_d = {31'h0000_0000, flag_q};
            end
            else if (hit_en)
            begin
                rdata_d = {31'h0000_0000, irq_en_q};
            end
            else if (hit_edge)
            begin
                rdata_d = {31'h0000_0000, pol_q};
            end
            else
            begin
                rdata_d = 32'h0000_0000;
            end
        end
        irq_d = flag_d && irq_en_d;
    end

    // Register file and counter registers
    always_ff @(posedge mclk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            mode_q   <= rlt_mode_s'(`RLT_MODE_RESET);
            count_q  <= `RLT_COUNT_RESET;
            reload_q <= `RLT_RELOAD_RESET;
            gate_q   <= `RLT_GATE_RESET;
            flag_q   <= 1'b0;
            irq_en_q <= 1'b0;
            pol_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            ready_q  <= 1'b0;
            err_q    <= 1'b0;
            irq_q    <= 1'b0;
        end
        else
        begin
            mode_q   <= mode_d;
            count_q  <= count_d;
            reload_q <= reload_d;
            gate_q   <= gate_d;
            flag_q   <= flag_d;
            irq_en_q <= irq_en_d;
            pol_q    <= pol_d;
            rdata_q  <= rdata_d;
            ready_q  <= ready_d;
            err_q    <= err_d;
            irq_q    <= irq_d;
        end
    end

    assign prdata_o       = rdata_q;
    assign pready_o       = ready_q;
    assign pslverr_o      = err_q;
    assign overflow_irq_o = irq_q;

endmodule // rlt_timer

// ===== rlt_defines.svh
`ifndef RLT_DEFINES_SVH
`define RLT_DEFINES_SVH

// Printed offsets are not all multiples of four: index, byte address = 4*idx
`define RLT_IDX_MODE        16'hffb4
`define RLT_IDX_COUNT       16'hffb5
`define RLT_IDX_GATE        16'hfffa
`define RLT_IDX_IRQ_REQ     16'hffb0
`define RLT_IDX_IRQ_EN      16'hffb1
`define RLT_IDX_EDGE_SEL    16'hffb2

// Mode register fields
`define RLT_MODE_RELOAD_BIT 7
`define RLT_MODE_HWDIR_BIT  6
`define RLT_MODE_SWDIR_BIT  5
`define RLT_MODE_RSVD_MASK  8'h18
`define RLT_MODE_WR_MASK    8'he7
`define RLT_MODE_RESET      8'h18

// Gate register
`define RLT_GATE_STBY_BIT   1
`define RLT_GATE_RESET      8'hff

// Counter and reload reset values, counter wrap limits
`define RLT_COUNT_RESET     8'h00
`define RLT_RELOAD_RESET    8'h00
`define RLT_COUNT_MAX       8'hff
`define RLT_COUNT_MIN       8'h00

// Prescaler taps on a 13-bit free-running divider
`define RLT_PRE_WIDTH       13
`define RLT_TAP_8192        12
`define RLT_TAP_2048        10
`define RLT_TAP_512         8
`define RLT_TAP_64          5
`define RLT_TAP_16          3
`define RLT_TAP_4           1

// Clock select codes
`define RLT_CS_SUB4         3'h6
`define RLT_CS_EVENT        3'h7

`endif

// ===== rlt_pkg.sv
package rlt_pkg;

    // Clock source decode
    typedef enum logic [2:0] {
        RLT_CS_D8192 = 3'b000,
        RLT_CS_D2048 = 3'b001,
        RLT_CS_D512  = 3'b010,
        RLT_CS_D64   = 3'b011,
        RLT_CS_D16   = 3'b100,
        RLT_CS_D4    = 3'b101,
        RLT_CS_SUBD4 = 3'b110,
        RLT_CS_EXT   = 3'b111
    } rlt_clk_sel_e;

    // Mode register fields
    typedef struct packed {
        logic         reload_mode_bit;
        logic         hw_direction_bit;
        logic         sw_direction_bit;
        logic [1:0]   rsvd;
        rlt_clk_sel_e clock_sel;
    } rlt_mode_s;

    // APB access phase in one bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [17:0] addr;
        logic [31:0] wdata;
    } rlt_apb_req_s;

endpackage

// ===== rlt_pins_model.sv
`timescale 1ns/1ps
// Far-side pins: event source, direction level, sub-clock
module rlt_pins_model
    import rlt_pkg::*;
(
    input  wire logic mclk_i,   // System clock for pacing
    output logic      event_o,  // Event pin, idle low
    output logic      dir_o,    // Direction pin level
    output logic      sub_o     // Sub-clock, still between bursts
);
    // Idle levels from time zero
    initial
    begin
        event_o = 1'b0;
        dir_o   = 1'b0;
        sub_o   = 1'b0;
    end

    // Six cycles each way, wide enough for the two-flop sync
    task ev(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            event_o <= 1'b1;
            repeat (6) @(posedge mclk_i);
            event_o <= 1'b0;
            repeat (6) @(posedge mclk_i);
        end
    endtask

    // Direction level, set well ahead of any edge
    task dir(input logic v);
        @(posedge mclk_i);
        dir_o <= v;
    endtask

    // Sub-clock runs only while a burst is asked for
    task sub(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            sub_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            sub_o <= 1'b0;
            repeat (4) @(posedge mclk_i);
        end
    endtask
endmodule // rlt_pins_model

// ===== rlt_monitor.sv
`timescale 1ns/1ps
`include "rlt_defines.svh"
module rlt_monitor
    import rlt_pkg::*;
(
    input wire logic        mclk_i,
    input wire logic        nrst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        sub_clk_i,
    input wire logic        event_input_pin_i,
    input wire logic        count_direction_pin_i,
    input wire logic        overflow_irq_o
);
    localparam logic [17:0] MODE_A = {`RLT_IDX_MODE, 2'b00}; // Mode word
    logic mapped; // Address hits one of the six words
    assign mapped = paddr_i inside {MODE_A, {`RLT_IDX_COUNT, 2'b00},
        {`RLT_IDX_GATE, 2'b00}, {`RLT_IDX_IRQ_REQ, 2'b00},
        {`RLT_IDX_IRQ_EN, 2'b00}, {`RLT_IDX_EDGE_SEL, 2'b00}};

    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("ready held past one cycle");
    ready_wait_a: assert property
        (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer after one wait state");
    ready_cause_a: assert property
        (pready_o |-> $past(psel_i && penable_i))
        else $error("ready without an access");
    err_with_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error outside ready");
    err_decode_a: assert property (pready_o |-> pslverr_o == !mapped)
        else $error("error flag does not match decode");
    rsvd_ones_a: assert property
        (pready_o && !pwrite_i && paddr_i == MODE_A |->
            prdata_o[4:3] == 2'b11)
        else $error("reserved mode bits not one");
    upper_zero_a: assert property
        (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    // A clear lands with ready, so the fall is seen while ready stands
    irq_clear_a: assert property
        ($fell(overflow_irq_o) |-> pready_o && pwrite_i)
        else $error("request dropped without a write");

    wr_cov: cover property (pready_o && pwrite_i);
    rd_cov: cover property (pready_o && !pwrite_i);
    irq_cov: cover property ($rose(overflow_irq_o));
endmodule // rlt_monitor

bind rlt_timer rlt_monitor mon (.mclk_i, .nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .sub_clk_i, .event_input_pin_i, .count_direction_pin_i,
    .overflow_irq_o);

// ===== tb.sv
`timescale 1ns/1ps
`include "rlt_defines.svh"
module tb
    import rlt_pkg::*;
;
    typedef struct packed {
        logic [15:0] idx;
        logic [7:0]  wd;
        logic [31:0] exp;
        logic        err;
    } rlt_row_s; // Write, read back, expected data and error

    localparam logic [15:0] MD = `RLT_IDX_MODE;  // Mode index
    localparam logic [15:0] CT = `RLT_IDX_COUNT; // Count/reload index
    localparam logic [15:0] GT = `RLT_IDX_GATE;  // Gate index
    localparam logic [15:0] FL = `RLT_IDX_IRQ_REQ;
    localparam logic [15:0] EN = `RLT_IDX_IRQ_EN;
    localparam logic [15:0] ES = `RLT_IDX_EDGE_SEL;
    localparam rlt_row_s ROWS [6] = '{
        '{MD, 8'h00, 32'h00000018, 1'b0}, '{MD, 8'he7, 32'h000000ff, 1'b0},
        '{MD, 8'h25, 32'h0000003d, 1'b0}, '{MD, 8'h00, 32'h00000018, 1'b0},
        '{GT, 8'h5a, 32'h0000005a, 1'b0}, '{16'h0100, 8'h55, 32'h0, 1'b1}};

    logic        mclk_i = 1'b0;  // 8 ns clock
    logic        nrst_i;         // Driven low by the first reset
    logic        psel_i;         // Bus request, idled at time zero
    logic        penable_i;
    logic        pwrite_i;
    logic [17:0] paddr_i;
    logic [31:0] pwdata_i;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        overflow_irq_o;
    logic        ev_w;           // Pins from the far-side model
    logic        dir_w;
    logic        sub_w;
    logic [31:0] rd_v;           // Data taken at the ready edge
    logic        er_v;           // Error taken at the ready edge
    int          mismatches = 0;
    int          compares = 0;

    always #4 mclk_i = ~mclk_i;

    rlt_timer dut (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .sub_clk_i(sub_w), .event_input_pin_i(ev_w),
        .count_direction_pin_i(dir_w), .overflow_irq_o);
    rlt_pins_model pm (.mclk_i, .event_o(ev_w), .dir_o(dir_w), .sub_o(sub_w));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high
    // at a rising edge, data and error are taken at that same edge
    task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= {24'h000000, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // No wait count assumed; only the watchdog ends a hang
        do
            @(posedge mclk_i);
        while (pready_o !== 1'b1);
        rd_v = prdata_o;
        er_v = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] wd);
        apb(1'b1, idx, wd);
    endtask

    task rdc(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd_v, exp);
    endtask

    // Request line, looked at once settled
    task irq(input logic exp);
        @(negedge mclk_i);
        chk({31'h0, overflow_irq_o}, {31'h0, exp});
    endtask

    task do_reset;
        nrst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
    endtask

    task end_of_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #100000;
        mismatches++;
        end_of_test;
    end

    initial
    begin
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        pwrite_i <= 1'b0;
        paddr_i <= 18'h00000;
        pwdata_i <= 32'h00000000;
        do_reset;
        rdc(MD, 32'h18);
        rdc(CT, 32'h00);
        rdc(GT, 32'hff);
        rdc(FL, 32'h00);
        irq(1'b0);
        foreach (ROWS[i])
        begin
            wr(ROWS[i].idx, ROWS[i].wd);
            rdc(ROWS[i].idx, ROWS[i].exp);
            chk({31'h0, er_v}, {31'h0, ROWS[i].err});
        end
        wr(GT, 8'hff);
        wr(FL, 8'h00);
        // Edge polarity chosen before the event code goes in
        wr(ES, 8'h01);
        wr(EN, 8'h01);
        wr(MD, 8'h07);
        wr(CT, 8'hfe);
        rdc(CT, 32'hfe);
        pm.ev(2);
        rdc(CT, 32'h00);
        rdc(FL, 32'h01);
        irq(1'b1);
        wr(FL, 8'h00);
        rdc(FL, 32'h00);
        irq(1'b0);
        // Down count with reload: 01, 00, then underflow back to 01
        wr(MD, 8'ha7);
        wr(CT, 8'h01);
        pm.ev(2);
        rdc(CT, 32'h01);
        rdc(FL, 32'h01);
        pm.dir(1'b1);
        wr(MD, 8'hc7);
        wr(CT, 8'h10);
        pm.ev(1);
        rdc(CT, 32'h0f);
        pm.dir(1'b0);
        pm.ev(1);
        rdc(CT, 32'h10);
        wr(ES, 8'h00);
        wr(MD, 8'h07);
        wr(CT, 8'h20);
        pm.ev(1);
        rdc(CT, 32'h21);
        // Standby: events ignored, reload still lands in the counter
        wr(GT, 8'hfd);
        wr(CT, 8'h5a);
        pm.ev(2);
        rdc(CT, 32'h5a);
        wr(GT, 8'hff);
        wr(MD, 8'h06);
        wr(CT, 8'h40);
        pm.sub(8);
        repeat (4) @(posedge mclk_i);
        rdc(CT, 32'h42);
        // Windows of whole divider periods, so the divider phase is moot
        wr(MD, 8'h04);
        wr(CT, 8'h00);
        repeat (13) @(posedge mclk_i);
        rdc(CT, 32'h01);
        wr(MD, 8'h03);
        wr(CT, 8'h00);
        repeat (125) @(posedge mclk_i);
        rdc(CT, 32'h02);
        wr(GT, 8'hfd);
        do_reset;
        rdc(MD, 32'h18);
        rdc(CT, 32'h00);
        rdc(GT, 32'hff);
        end_of_test;
    end
endmodule // tb
